/* File: hw/wdrc_pkg.sv */
// Package: register map, field layout and timing for the watchdog control
// How it works
// - Baud doubler bit one doubles serial port 1 rate, zero gives nominal.
// - Power-on flag set by power-on reset, kept through all other resets.
// - Power-fail enable gates interrupt; in stop also needs band-gap select.
// - Power-fail event or software write of one sets flag and interrupt.
// - Timeout sets warning flag 512 clocks before any watchdog reset.
// - Warning flag writable only by timed access; software clears it.
// - Watchdog reset sets reset flag, power-on clears it, else kept.
// - Software setting the reset flag never causes a watchdog reset.
// - With reset enable zero the watchdog leaves reset flag alone.
// - Reset enable one makes timeout reset device; zero, counter runs on.
// - Reset enable timed-access only, kept through non-power-on resets.
// - Timed-access write of one to restart bit clears watchdog count.
// - Restart bit always reads back as zero.
package wdrc_pkg;
  localparam logic [9:0] WDRC_CTRL_INDEX = 10'h0FF;
  localparam logic [11:0] WDRC_CTRL_ADDR = {WDRC_CTRL_INDEX, 2'h0};
  localparam logic [11:0] WDRC_IRQ_STAT_ADDR = 12'h400;
  localparam logic [11:0] WDRC_IRQ_MASK_ADDR = 12'h404;
  localparam logic [11:0] WDRC_UNLOCK_ADDR = 12'h408;
  localparam logic [11:0] WDRC_STATUS_ADDR = 12'h40C;
  localparam logic [7:0] WDRC_KEY1 = 8'hAA;
  localparam logic [7:0] WDRC_KEY2 = 8'h55;
  localparam logic [2:0] WDRC_TA_WINDOW = 3'h3;
  localparam int WDRC_WARN_CLOCKS = 512;
  localparam int WDRC_TIMEOUT_DEF = 131072;
  localparam int WDRC_BIT_BAUD = 7;
  localparam int WDRC_BIT_POR = 6;
  localparam int WDRC_BIT_PFEN = 5;
  localparam int WDRC_BIT_PFF = 4;
  localparam int WDRC_BIT_WARN = 3;
  localparam int WDRC_BIT_WRF = 2;
  localparam int WDRC_BIT_EN = 1;
  localparam int WDRC_BIT_RST = 0;
  localparam int WDRC_EV_PF = 0;
  localparam int WDRC_EV_WARN = 1;
  localparam int WDRC_EV_WDR = 2;
  localparam logic [2:0] WDRC_EV_ZERO = 3'h0;
  localparam logic [31:0] WDRC_ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {TA_IDLE, TA_KEY1, TA_OPEN} wdrc_ta_e;

  typedef struct packed {
    logic baud_double_port1;
    logic power_on_flag;
    logic power_fail_int_enable;
    logic power_fail_flag;
    logic wdog_warning_flag;
    logic wdog_reset_flag;
    logic wdog_reset_enable;
  } wdrc_ctrl_s;

  typedef struct packed {
    wdrc_ctrl_s ctrl;
    wdrc_ta_e ta_state;
    logic [2:0] ta_cnt;
    logic [31:0] wd_cnt;
    logic warn_phase;
    logic [9:0] warn_cnt;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic pf_irq_prev;
    logic wdog_rst_pulse;
    logic [31:0] prdata;
    logic pslverr;
  } wdrc_state_s;
endpackage

/* File: hw/wdrc_ctrl.sv */
// Watchdog, reset-cause flags and power-fail control behind an APB slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module wdrc_ctrl
  import wdrc_pkg::*;
#(
  parameter int TIMEOUT_CLOCKS = WDRC_TIMEOUT_DEF
) (
  input wire logic mclk, // System clock, 250 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic por_event, // Reset was a power-on reset (held at release)
  input wire logic stop_mode, // Core in stop mode
  input wire logic bandgap_stop_select, // Band-gap active in stop
  input wire logic power_fail_detect, // Supply below threshold, level
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error, unmapped address
  output logic baud_double_port1, // Serial port 1 rate doubler
  output logic power_fail_irq, // Power-fail interrupt request
  output logic wdog_reset_req, // One-cycle device reset request
  output logic irq // Summary interrupt, level
);

  wdrc_state_s st_r;
  wdrc_state_s st_nxt;
  logic boot_r; // First edge after release captures reset cause

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic ta_ok;
  logic [7:0] wb;
  logic pf_src;
  logic timeout;
  logic warn_done;
  logic [2:0] ev;
  logic [7:0] ctrl_byte;
  logic ans_r;

  always_comb begin
    acc = psel && penable;
    // Writes land on the completing edge only; a repeat would break unlock
    wr = acc && ans_r && pwrite && pstrb[0];
    rd = acc && !pwrite;
    wb = pwdata[7:0];
    ta_ok = (st_r.ta_state == TA_OPEN);
    ev = WDRC_EV_ZERO;
    st_nxt = st_r;
    st_nxt.wdog_rst_pulse = 1'b0;
    st_nxt.prdata = WDRC_ZERO32;
    st_nxt.pslverr = 1'b0;
    ctrl_byte = {st_r.ctrl, 1'b0};

    // ----------------------------------------------------------------
    // Timed-access unlock
    // ----------------------------------------------------------------
    unique case (st_r.ta_state)
      TA_IDLE: begin
        if (wr && hit(paddr, WDRC_UNLOCK_ADDR) && wb == WDRC_KEY1) begin
          st_nxt.ta_state = TA_KEY1;
        end
      end
      TA_KEY1: begin
        if (wr && hit(paddr, WDRC_UNLOCK_ADDR) && wb == WDRC_KEY2) begin
          st_nxt.ta_state = TA_OPEN;
          st_nxt.ta_cnt = WDRC_TA_WINDOW;
        end else if (wr) begin
          st_nxt.ta_state = TA_IDLE;
        end
      end
      TA_OPEN: begin
        // Window closes after one protected write or on expiry
        if (wr && hit(paddr, WDRC_CTRL_ADDR)) begin
          st_nxt.ta_state = TA_IDLE;
        end else if (st_r.ta_cnt == 3'h0) begin
          st_nxt.ta_state = TA_IDLE;
        end else begin
          st_nxt.ta_cnt = st_r.ta_cnt - 3'h1;
        end
      end
      default: begin
        st_nxt.ta_state = TA_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Watchdog counter and warning delay
    // ----------------------------------------------------------------
    timeout = !st_r.warn_phase &&
              (st_r.wd_cnt == 32'(TIMEOUT_CLOCKS - 1));
    warn_done = st_r.warn_phase &&
                (st_r.warn_cnt == 10'(WDRC_WARN_CLOCKS - 1));
    if (st_r.warn_phase) begin
      st_nxt.warn_cnt = st_r.warn_cnt + 10'h1;
    end else begin
      st_nxt.wd_cnt = st_r.wd_cnt + 32'h1;
    end
    if (timeout) begin
      st_nxt.ctrl.wdog_warning_flag = 1'b1;
      st_nxt.warn_phase = 1'b1;
      st_nxt.warn_cnt = 10'h0;
      ev[WDRC_EV_WARN] = 1'b1;
    end
    if (warn_done) begin
      // Without reset enable the counter simply restarts
      st_nxt.warn_phase = 1'b0;
      st_nxt.wd_cnt = 32'h0;
      if (st_r.ctrl.wdog_reset_enable) begin
        st_nxt.wdog_rst_pulse = 1'b1;
        ev[WDRC_EV_WDR] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr && hit(paddr, WDRC_CTRL_ADDR)) begin
      st_nxt.ctrl.baud_double_port1 = wb[WDRC_BIT_BAUD];
      st_nxt.ctrl.power_fail_int_enable = wb[WDRC_BIT_PFEN];
      st_nxt.ctrl.power_fail_flag = wb[WDRC_BIT_PFF];
      st_nxt.ctrl.wdog_reset_flag = wb[WDRC_BIT_WRF];
      if (ta_ok) begin
        st_nxt.ctrl.power_on_flag = wb[WDRC_BIT_POR];
        st_nxt.ctrl.wdog_warning_flag = wb[WDRC_BIT_WARN];
        st_nxt.ctrl.wdog_reset_enable = wb[WDRC_BIT_EN];
        if (wb[WDRC_BIT_RST]) begin
          st_nxt.wd_cnt = 32'h0;
          st_nxt.warn_phase = 1'b0;
          st_nxt.wdog_rst_pulse = 1'b0;
        end
      end
    end
    if (wr && hit(paddr, WDRC_IRQ_STAT_ADDR)) begin
      st_nxt.irq_stat = st_r.irq_stat & ~wb[2:0];
    end
    if (wr && hit(paddr, WDRC_IRQ_MASK_ADDR)) begin
      st_nxt.irq_mask = wb[2:0];
    end

    // ----------------------------------------------------------------
    // Power-fail and event capture; hardware set wins over clear
    // ----------------------------------------------------------------
    pf_src = power_fail_detect && !st_r.pf_irq_prev;
    st_nxt.pf_irq_prev = power_fail_detect;
    if (pf_src) begin
      st_nxt.ctrl.power_fail_flag = 1'b1;
      ev[WDRC_EV_PF] = 1'b1;
    end
    if (st_nxt.wdog_rst_pulse) begin
      st_nxt.ctrl.wdog_reset_flag = 1'b1;
    end
    if (timeout) begin
      st_nxt.ctrl.wdog_warning_flag = 1'b1;
    end
    st_nxt.irq_stat = st_nxt.irq_stat | ev;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    if (rd) begin
      if (hit(paddr, WDRC_CTRL_ADDR)) begin
        st_nxt.prdata = {24'h0, ctrl_byte};
      end else if (hit(paddr, WDRC_IRQ_STAT_ADDR)) begin
        st_nxt.prdata = {29'h0, st_r.irq_stat};
      end else if (hit(paddr, WDRC_IRQ_MASK_ADDR)) begin
        st_nxt.prdata = {29'h0, st_r.irq_mask};
      end else if (hit(paddr, WDRC_STATUS_ADDR)) begin
        st_nxt.prdata = {30'h0, st_r.warn_phase, ta_ok};
      end else if (!hit(paddr, WDRC_UNLOCK_ADDR)) begin
        st_nxt.pslverr = 1'b1;
      end
    end else if (acc && !(hit(paddr, WDRC_CTRL_ADDR) ||
        hit(paddr, WDRC_IRQ_STAT_ADDR) || hit(paddr, WDRC_IRQ_MASK_ADDR) ||
        hit(paddr, WDRC_UNLOCK_ADDR) || hit(paddr, WDRC_STATUS_ADDR))) begin
      st_nxt.pslverr = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // State register; reset-cause flags survive non-power-on resets
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Cause flags and reset enable have no reset term: a warm reset
      // must leave them alone, and a cold start sets them below
      st_r.ctrl.baud_double_port1 <= 1'b0;
      st_r.ctrl.power_fail_int_enable <= 1'b0;
      st_r.ctrl.power_fail_flag <= 1'b0;
      st_r.ctrl.wdog_warning_flag <= 1'b0;
      st_r.ta_state <= TA_IDLE;
      st_r.ta_cnt <= 3'h0;
      st_r.wd_cnt <= 32'h0;
      st_r.warn_phase <= 1'b0;
      st_r.warn_cnt <= 10'h0;
      st_r.irq_stat <= 3'h0;
      st_r.irq_mask <= 3'h0;
      st_r.pf_irq_prev <= 1'b0;
      st_r.wdog_rst_pulse <= 1'b0;
      st_r.prdata <= WDRC_ZERO32;
      st_r.pslverr <= 1'b0;
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      st_r <= st_nxt;
      if (boot_r && por_event) begin
        // Cold start: only now are the cause flags defined
        st_r.ctrl.power_on_flag <= 1'b1;
        st_r.ctrl.wdog_reset_flag <= 1'b0;
        st_r.ctrl.wdog_reset_enable <= 1'b0;
      end
    end
  end

  // A slave read pulse is registered, so answer one cycle into access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ans_r <= 1'b0;
    end else begin
      ans_r <= psel && penable && !ans_r;
    end
  end

  always_comb begin
    pready = ans_r;
    prdata = st_r.prdata;
    pslverr = st_r.pslverr && ans_r;
    baud_double_port1 = st_r.ctrl.baud_double_port1;
    wdog_reset_req = st_r.wdog_rst_pulse;
    power_fail_irq = st_r.ctrl.power_fail_flag &&
                     st_r.ctrl.power_fail_int_enable &&
                     (!stop_mode || bandgap_stop_select);
    // A set mask bit silences its source
    irq = |(st_r.irq_stat & ~st_r.irq_mask);
  end

endmodule

/* File: sim/wdrc_ctrl_assertions.sv */
// Port-level assertions for the watchdog control block
`timescale 1ns/10ps
module wdrc_ctrl_chk
  import wdrc_pkg::*;
#(
  parameter int TIMEOUT_CLOCKS = 64
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic stop_mode, // Stop mode
  input wire logic bandgap_stop_select, // Band-gap in stop
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic baud_double_port1, // Doubler
  input wire logic power_fail_irq, // Power-fail request
  input wire logic wdog_reset_req // Reset request
);
  // ----------------------------------------
  // Age since reset
  // ----------------------------------------
  // Restarts only shorten the real count, so age is a safe upper bound
  logic [15:0] age_r;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      age_r <= 16'h0000;
    else if (age_r != 16'hFFFF)
      age_r <= age_r + 16'h0001;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_restart_zero: assert property (pready && !pwrite &&
    paddr == WDRC_CTRL_ADDR |-> prdata[WDRC_BIT_RST] == 1'b0)
    else $error("restart bit read as one");
  a_ctrl_width: assert property (pready && !pwrite &&
    paddr == WDRC_CTRL_ADDR |-> prdata[31:8] == 24'h000000)
    else $error("control upper bits set");
  a_baud_hold: assert property (!(psel && penable && pwrite)
    |=> $stable(baud_double_port1)) else $error("doubler moved");
  a_pf_stop_gate: assert property (power_fail_irq && stop_mode
    |-> bandgap_stop_select) else $error("stop irq without band-gap");
  a_wdr_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
    else $error("reset request too long");
  a_wdr_late: assert property (wdog_reset_req
    |-> int'(age_r) >= TIMEOUT_CLOCKS + 500) else $error("reset too early");
endmodule

bind wdrc_ctrl wdrc_ctrl_chk #(.TIMEOUT_CLOCKS(TIMEOUT_CLOCKS)) wdrc_ctrl_chk_i (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .stop_mode(stop_mode),
  .bandgap_stop_select(bandgap_stop_select), .pready(pready),
  .prdata(prdata), .baud_double_port1(baud_double_port1),
  .power_fail_irq(power_fail_irq), .wdog_reset_req(wdog_reset_req));

/* File: sim/tb_wdrc_ctrl.sv */
// Self-checking testbench for the watchdog control block
`timescale 1ns/10ps
module tb_wdrc_ctrl import wdrc_pkg::*;;
  localparam int TO = 64;
  logic mclk = 0;
  logic arst_n = 0;
  logic por_event = 1;
  logic stop_mode = 0;
  logic bandgap_stop_select = 0;
  logic power_fail_detect = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, baud_double_port1, power_fail_irq, irq;
  logic wdog_reset_req, last_err;
  logic [31:0] prdata, rdat;
  int errors = 0;
  int checks = 0;
  int n;
  wdrc_ctrl #(.TIMEOUT_CLOCKS(TO)) wdrc_ctrl_i (.mclk(mclk),
    .arst_n(arst_n), .por_event(por_event), .stop_mode(stop_mode),
    .bandgap_stop_select(bandgap_stop_select),
    .power_fail_detect(power_fail_detect), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .baud_double_port1(baud_double_port1), .power_fail_irq(power_fail_irq),
    .wdog_reset_req(wdog_reset_req), .irq(irq));
  initial forever #2 mclk = ~mclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic finish_test();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // Leaves the bus held so unlock steps stay inside the window
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      finish_test();
    end
    rdat = prdata;
    last_err = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [11:0] a, input int e, input string s);
    apb(1'b0, a, 0);
    idle();
    chk(s, e, rdat);
  endtask
  task automatic ta(input int d);
    apb(1'b1, WDRC_UNLOCK_ADDR, WDRC_KEY1);
    apb(1'b1, WDRC_UNLOCK_ADDR, WDRC_KEY2);
    apb(1'b1, WDRC_CTRL_ADDR, d);
    idle();
  endtask
  task automatic pulses(input int c);
    n = 0;
    repeat (c) begin
      @(posedge mclk);
      if (wdog_reset_req === 1'b1)
        n++;
    end
  endtask
  task automatic s_power_fail();
    wr(WDRC_CTRL_ADDR, 'h20);
    power_fail_detect <= 1'b1;
    pulses(3);
    chk("pf irq", 1, power_fail_irq);
    chk("irq", 1, irq);
    wr(WDRC_IRQ_MASK_ADDR, 1);
    chk("irq masked", 0, irq);
    wr(WDRC_IRQ_STAT_ADDR, 7);
    wr(WDRC_IRQ_MASK_ADDR, 0);
    chk("irq cleared", 0, irq);
    wr(WDRC_CTRL_ADDR, 'h20);
    chk("pf flag clr", 0, power_fail_irq);
    power_fail_detect <= 1'b0;
    stop_mode <= 1'b1;
    pulses(2);
    power_fail_detect <= 1'b1;
    pulses(3);
    chk("pf stop no bg", 0, power_fail_irq);
    bandgap_stop_select <= 1'b1;
    pulses(2);
    chk("pf stop bg", 1, power_fail_irq);
    wr(WDRC_CTRL_ADDR, 'h20);
    wr(WDRC_CTRL_ADDR, 'h30);
    chk("pf sw set", 1, power_fail_irq);
    wr(WDRC_CTRL_ADDR, 'h10);
    chk("pf disabled", 0, power_fail_irq);
    stop_mode <= 1'b0;
    bandgap_stop_select <= 1'b0;
    power_fail_detect <= 1'b0;
  endtask
  task automatic s_wdog();
    ta('h01);
    rd(WDRC_CTRL_ADDR, 'h00, "ctrl cleared");
    pulses(30);
    rd(WDRC_CTRL_ADDR, 'h00, "no early warn");
    rd(WDRC_STATUS_ADDR, 'h00, "restart phase");
    pulses(700);
    chk("pulses off", 0, n);
    rd(WDRC_CTRL_ADDR, 'h08, "warn only");
    wr(WDRC_CTRL_ADDR, 'h04);
    pulses(20);
    chk("sw flag pulses", 0, n);
    rd(WDRC_CTRL_ADDR, 'h0C, "warn kept");
    ta('h03);
    n = 0;
    while (wdog_reset_req !== 1'b1 && n < 700) begin
      @(posedge mclk);
      n++;
    end
    chk("reset delay", 1, n >= TO + 500 && n <= TO + 520);
    rd(WDRC_CTRL_ADDR, 'h0E, "after reset");
    chk("baud off", 0, baud_double_port1);
  endtask
  task automatic s_basic();
    rd(WDRC_CTRL_ADDR, 'h40, "reset value");
    por_event <= 1'b0;
    wr(WDRC_CTRL_ADDR, 'h82);
    rd(WDRC_CTRL_ADDR, 'hC0, "plain write");
    chk("baud out", 1, baud_double_port1);
    rd('h500, 0, "unmapped data");
    chk("unmapped err", 1, last_err);
  endtask
  // Bus is idle on entry; first request goes out after the boot edge
  task automatic pulse_reset(input logic cold);
    por_event <= cold;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic s_resets();
    pulse_reset(1'b0);
    rd(WDRC_CTRL_ADDR, 'h06, "warm keeps");
    pulse_reset(1'b1);
    rd(WDRC_CTRL_ADDR, 'h40, "cold reset");
    pulse_reset(1'b0);
    rd(WDRC_CTRL_ADDR, 'h40, "warm keeps por");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    s_basic();
    s_power_fail();
    s_wdog();
    s_resets();
    finish_test();
  end
endmodule
